// >>> hw/irq_ctrl_pkg.sv
/*
  Shared constants for the module interrupt controller and the
  processor core end that acknowledges it.
  Assumes one 25 MHz clock and a synchronous active-high reset on both ends.
*/
package irq_ctrl_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned NUM_SOURCES = 32;
  localparam int unsigned LEVEL_W = 3;
  localparam int unsigned VECTOR_W = 8;
  localparam int unsigned SRC_IDX_W = 5;
  localparam int unsigned SPI_EVENT_W = 8;
  localparam int unsigned SER_EVENT_W = 16;
  // ==========================================================
  // Source positions (ranking: higher index ranks higher)
  localparam logic [31:0] SPI_SOURCE_SEL = 32'h0000_0020;
  localparam int unsigned SPI_SOURCE_BIT = 5;
  localparam int unsigned SER_SOURCE_BIT = 30;
  // ==========================================================
  // Event register values
  localparam logic [7:0] SPI_CLEAR_ALL = 8'hff;
  localparam logic [7:0] SPI_EVENT_IMPL = 8'h37;
  // ==========================================================
  // Register offsets of the controller's own register port
  localparam logic [3:0] ADDR_MASK = 4'h0;
  localparam logic [3:0] ADDR_PENDING = 4'h1;
  localparam logic [3:0] ADDR_IN_SERVICE = 4'h2;
  localparam logic [3:0] ADDR_SPI_EVENT = 4'h3;
  localparam logic [3:0] ADDR_SPI_EVMASK = 4'h4;
  localparam logic [3:0] ADDR_SER_EVENT = 4'h5;
  localparam logic [3:0] ADDR_SER_EVMASK = 4'h6;
  localparam logic [3:0] ADDR_LEVEL = 4'h7;
  localparam logic [3:0] ADDR_VEC_BASE = 4'h8;
  // ==========================================================
  // Reset values
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [2:0] LEVEL_RESET = 3'h4;
  localparam logic [7:0] VEC_BASE_RESET = 8'h40;
endpackage : irq_ctrl_pkg

// >>> hw/irq_link_if.sv
/*
  Carrier between the interrupt controller and the processor core end.
  Assumes both ends run on ref_clk; no tri-state wires are involved.
*/
`timescale 1ns/1ns
interface irq_link_if;
  import irq_ctrl_pkg::*;
  logic irq_req;
  logic [LEVEL_W-1:0] irq_level;
  logic iack;
  logic [VECTOR_W-1:0] vector;
  logic vector_valid;
  logic return_done;
  modport ctrl (output irq_req, output irq_level, input iack, output vector, output vector_valid, input return_done);
  modport core (input irq_req, input irq_level, output iack, input vector, input vector_valid, output return_done);
endinterface : irq_link_if

// >>> hw/module_irq_controller.sv
/*
  Module interrupt controller: ranks module sources, presents the winner to
  the core, answers the acknowledge with a vector, keeps pending, mask and
  in-service bookkeeping, and holds the SPI and serial channel event/mask
  registers. Assumes the core end drives iack one cycle at a time only while
  irq_req is high, and pulses return_done on each return from exception.
*/
`timescale 1ns/1ns
// Operation
// - present only highest ranked pending source
// - clear request once vector is supplied
// - re-rank remaining requests, present next
// - core refuses levels at or below mask
// - set in-service bit on acknowledge
// - in-service blocks own and lower positions
// - software clears in-service bit after handling
// - blocked requests still recorded as pending
// - software may lower core mask nesting
// - mask bit one enables source request
// - masked source still shows pending
// - software may poll pending with all masked
// - peripherals own per-event mask registers
// - write one clears event bit
// - unmasked events re-pend source after return
// - handler clears events, in-service, then returns
// - SPI source sits at mask bit 0x20
// - writing 0xff clears all SPI events
// - writing 0x37 enables all SPI events
// - event mask one enables, resets zero
module module_irq_controller
  import irq_ctrl_pkg::*;
#(
  parameter int unsigned N = NUM_SOURCES
)
(
  input wire logic ref_clk,
  input wire logic reset,
  irq_link_if.ctrl link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [SPI_EVENT_W-1:0] spi_event_in,
  input wire logic [SER_EVENT_W-1:0] ser_event_in,
  input wire logic [N-1:0] src_req_in
);
  // ==========================================================
  // Elaboration checks
  if (N != NUM_SOURCES) $error("module_irq_controller: only 32 sources are served");

  typedef struct packed {
    logic [31:0] mask_reg;
    logic [31:0] pending_reg;
    logic [31:0] in_service_reg;
    logic [SPI_EVENT_W-1:0] spi_event_reg;
    logic [SPI_EVENT_W-1:0] spi_mask_reg;
    logic [SER_EVENT_W-1:0] ser_event_reg;
    logic [SER_EVENT_W-1:0] ser_mask_reg;
    logic [LEVEL_W-1:0] level_reg;
    logic [VECTOR_W-1:0] vec_base_reg;
    logic [31:0] rdata_reg;
    logic irq_req_reg;
    logic [VECTOR_W-1:0] vector_reg;
    logic vector_valid_reg;
  } state_type;

  state_type s_reg, s_next;

  // ==========================================================
  // Helpers
  // Highest set bit index; higher index ranks higher
  function automatic logic [SRC_IDX_W-1:0] top_index(input logic [31:0] v);
    logic [SRC_IDX_W-1:0] idx;
    idx = '0;
    for (int i = 0; i < 32; i++)
      if (v[i])
        idx = SRC_IDX_W'(i);
    return idx;
  endfunction : top_index

  // Mask of the given position and every lower one
  function automatic logic [31:0] at_or_below(input logic [SRC_IDX_W-1:0] idx);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 32; i++)
      if (SRC_IDX_W'(i) <= idx)
        m[i] = 1'b1;
    return m;
  endfunction : at_or_below

  logic [31:0] src_req;
  logic [31:0] eligible;
  logic [31:0] blocked;
  logic [SRC_IDX_W-1:0] win_idx;
  logic spi_line;
  logic ser_line;

  // Peripheral request lines from their enabled events
  assign spi_line = |(s_reg.spi_event_reg & s_reg.spi_mask_reg);
  assign ser_line = |(s_reg.ser_event_reg & s_reg.ser_mask_reg);

  // Combined raw requests of all sources
  always_comb
  begin
    src_req = src_req_in;
    src_req[SPI_SOURCE_BIT] = spi_line;
    src_req[SER_SOURCE_BIT] = ser_line;
  end

  // Ranking; in-service bits block their position and all lower ones
  always_comb
  begin
    blocked = '0;
    if (|s_reg.in_service_reg)
      blocked = at_or_below(top_index(s_reg.in_service_reg));
    eligible = s_reg.pending_reg & s_reg.mask_reg & ~blocked;
    win_idx = top_index(eligible);
  end

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    s_next = s_reg;
    s_next.vector_valid_reg = 1'b0;
    s_next.rdata_reg = RESET_ZERO;
    // Hardware event capture; set wins over software clear
    s_next.spi_event_reg = s_reg.spi_event_reg;
    s_next.ser_event_reg = s_reg.ser_event_reg;
    if (wr && addr == ADDR_SPI_EVENT)
      s_next.spi_event_reg = s_reg.spi_event_reg & ~wdata[SPI_EVENT_W-1:0];
    if (wr && addr == ADDR_SER_EVENT)
      s_next.ser_event_reg = s_reg.ser_event_reg & ~wdata[SER_EVENT_W-1:0];
    s_next.spi_event_reg = s_next.spi_event_reg | (spi_event_in & SPI_EVENT_IMPL);
    s_next.ser_event_reg = s_next.ser_event_reg | ser_event_in;
    // Plain configuration writes
    if (wr)
    begin
      case (addr)
        ADDR_MASK: s_next.mask_reg = wdata;
        ADDR_SPI_EVMASK: s_next.spi_mask_reg = wdata[SPI_EVENT_W-1:0];
        ADDR_SER_EVMASK: s_next.ser_mask_reg = wdata[SER_EVENT_W-1:0];
        ADDR_LEVEL: s_next.level_reg = wdata[LEVEL_W-1:0];
        ADDR_VEC_BASE: s_next.vec_base_reg = wdata[VECTOR_W-1:0];
        default: ;
      endcase
    end
    // Software clears in-service bits by writing ones
    if (wr && addr == ADDR_IN_SERVICE)
      s_next.in_service_reg = s_reg.in_service_reg & ~wdata;
    // Acknowledge: hand out vector, clear request, mark in service
    if (link.iack && s_reg.irq_req_reg)
    begin
      s_next.vector_reg = s_reg.vec_base_reg | VECTOR_W'(win_idx);
      s_next.vector_valid_reg = 1'b1;
      s_next.pending_reg[win_idx] = 1'b0;
      s_next.in_service_reg[win_idx] = 1'b1;
    end
    // Pending capture regardless of mask or blocking; done after the
    // acknowledge clear so a request in that same cycle is not lost
    s_next.pending_reg = s_next.pending_reg | src_req;
    // Return from exception re-captures whatever lines are still high
    if (link.return_done)
      s_next.pending_reg = s_next.pending_reg | src_req;
    // Peripheral sources follow their level: a line left high pends again
    // at once, a line whose events were cleared drops its pending bit
    s_next.pending_reg[SPI_SOURCE_BIT] = spi_line;
    s_next.pending_reg[SER_SOURCE_BIT] = ser_line;
    // Request to the core follows the re-ranked eligible set
    s_next.irq_req_reg = |eligible && !(link.iack && s_reg.irq_req_reg);
    // Reads answer one cycle later
    if (rd)
    begin
      case (addr)
        ADDR_MASK: s_next.rdata_reg = s_reg.mask_reg;
        ADDR_PENDING: s_next.rdata_reg = s_reg.pending_reg;
        ADDR_IN_SERVICE: s_next.rdata_reg = s_reg.in_service_reg;
        ADDR_SPI_EVENT: s_next.rdata_reg = 32'(s_reg.spi_event_reg);
        ADDR_SPI_EVMASK: s_next.rdata_reg = 32'(s_reg.spi_mask_reg);
        ADDR_SER_EVENT: s_next.rdata_reg = 32'(s_reg.ser_event_reg);
        ADDR_SER_EVMASK: s_next.rdata_reg = 32'(s_reg.ser_mask_reg);
        ADDR_LEVEL: s_next.rdata_reg = 32'(s_reg.level_reg);
        ADDR_VEC_BASE: s_next.rdata_reg = 32'(s_reg.vec_base_reg);
        default: s_next.rdata_reg = RESET_ZERO;
      endcase
    end
  end

  // ==========================================================
  // State register; all clear except level and vector base, so no source asks before enabled
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_reg <= '0;
      s_reg.level_reg <= LEVEL_RESET;
      s_reg.vec_base_reg <= VEC_BASE_RESET;
    end
    else
      s_reg <= s_next;
  end

  assign link.irq_req = s_reg.irq_req_reg;
  assign link.irq_level = s_reg.level_reg;
  assign link.vector = s_reg.vector_reg;
  assign link.vector_valid = s_reg.vector_valid_reg;
  assign rdata = s_reg.rdata_reg;
endmodule : module_irq_controller

// >>> hw/core_irq_end.sv
/*
  Processor core end: holds the 3-bit priority mask, takes requests only
  above it, runs the acknowledge, reports the vector to the user side and the
  return to the controller. Assumes the controller answers iack with vector_valid one cycle
  later.
*/
`timescale 1ns/1ns
module core_irq_end
  import irq_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  irq_link_if.core link,
  input wire logic [LEVEL_W-1:0] mask_in,
  input wire logic mask_load,
  input wire logic service_done,
  output logic [LEVEL_W-1:0] core_mask,
  output logic [VECTOR_W-1:0] taken_vector,
  output logic taken_valid,
  output logic busy
);
  typedef enum {IDLE, ACK, WAIT_VEC, SERVE} phase_type;

  typedef struct packed {
    phase_type phase;
    logic [LEVEL_W-1:0] mask_reg;
    logic [LEVEL_W-1:0] saved_mask_reg;
    logic iack_reg;
    logic return_reg;
    logic [VECTOR_W-1:0] vec_reg;
    logic valid_reg;
    logic busy_reg;
  } state_type;

  state_type s_reg, s_next;

  // ==========================================================
  // Acknowledge sequence; only levels above the mask are taken
  always_comb
  begin
    s_next = s_reg;
    s_next.iack_reg = 1'b0;
    s_next.return_reg = 1'b0;
    s_next.valid_reg = 1'b0;
    // Software may lower the mask to nest within the level
    if (mask_load)
      s_next.mask_reg = mask_in;
    case (s_reg.phase)
      IDLE:
        if (link.irq_req && link.irq_level > s_reg.mask_reg)
        begin
          s_next.iack_reg = 1'b1;
          s_next.phase = ACK;
        end
      ACK: s_next.phase = WAIT_VEC;
      WAIT_VEC:
        if (link.vector_valid)
        begin
          s_next.vec_reg = link.vector;
          s_next.valid_reg = 1'b1;
          s_next.saved_mask_reg = s_reg.mask_reg;
          s_next.mask_reg = link.irq_level;
          s_next.phase = SERVE;
        end
      SERVE:
        // Handler has cleared events and in-service before signalling
        if (service_done)
        begin
          s_next.return_reg = 1'b1;
          s_next.mask_reg = s_reg.saved_mask_reg;
          s_next.phase = IDLE;
        end
      default: s_next.phase = IDLE;
    endcase
    // Busy is registered so the output comes straight from a flip-flop
    s_next.busy_reg = s_next.phase != IDLE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_reg <= '0;
      s_reg.phase <= IDLE;
    end
    else
      s_reg <= s_next;
  end

  assign link.iack = s_reg.iack_reg;
  assign link.return_done = s_reg.return_reg;
  assign core_mask = s_reg.mask_reg;
  assign taken_vector = s_reg.vec_reg;
  assign taken_valid = s_reg.valid_reg;
  assign busy = s_reg.busy_reg;
endmodule : core_irq_end

// >>> sim/irq_link_props.sv
/*
  Checker for the link between controller and core end.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module irq_link_props
  import irq_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic irq_req,
  input wire logic [LEVEL_W-1:0] irq_level,
  input wire logic iack,
  input wire logic [VECTOR_W-1:0] vector,
  input wire logic vector_valid,
  input wire logic return_done
);
  // ==========
  // Link handshake
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  AST_ACK_VALID: assert property (iack && irq_req |=> vector_valid) else $error("no vector after ack");
  AST_REQ_DROP: assert property (iack && irq_req |=> !irq_req) else $error("request held after ack");
  AST_VALID_PULSE: assert property (vector_valid |=> !vector_valid) else $error("vector valid too long");
  AST_VALID_CAUSE: assert property (vector_valid |-> $past(iack && irq_req)) else $error("vector without ack");
  // Vector may only move when a new one is announced
  AST_VEC_STABLE: assert property (!vector_valid |-> $stable(vector)) else $error("vector moved");
  AST_IACK_ONLY_REQ: assert property (iack |-> irq_req) else $error("ack without request");
  AST_RETURN_PULSE: assert property (return_done |=> !return_done) else $error("return pulse too long");
  // Reset itself is the cause here, so it must not disable the check
  AST_RESET_IDLE: assert property (disable iff (1'b0) reset |=> !irq_req && !vector_valid)
    else $error("request during reset");
endmodule : irq_link_props

// >>> sim/comm_module_interrupt_controller_tb.sv
/*
  Testbench joining controller and core end through the link.
  Assumes package and link interface are compiled first.
*/
`timescale 1ns/1ns
module comm_module_interrupt_controller_tb;
  import irq_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic mask_load = 1'b0;
  logic service_done = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] src_req_in = 32'h0000_0000;
  logic [31:0] rdata;
  logic [7:0] spi_event_in = 8'h00;
  logic [7:0] taken_vector;
  logic [15:0] ser_event_in = 16'h0000;
  logic [2:0] mask_in = 3'h0;
  logic [2:0] core_mask;
  logic taken_valid;
  logic busy;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  irq_link_if link_if ();
  module_irq_controller module_irq_controller_inst (.ref_clk(ref_clk), .reset(reset), .link(link_if),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .spi_event_in(spi_event_in),
    .ser_event_in(ser_event_in), .src_req_in(src_req_in));
  core_irq_end core_irq_end_inst (.ref_clk(ref_clk), .reset(reset), .link(link_if), .mask_in(mask_in),
    .mask_load(mask_load), .service_done(service_done), .core_mask(core_mask), .taken_vector(taken_vector),
    .taken_valid(taken_valid), .busy(busy));
  irq_link_props irq_link_props_inst (.ref_clk(ref_clk), .reset(reset), .irq_req(link_if.irq_req),
    .irq_level(link_if.irq_level), .iack(link_if.iack), .vector(link_if.vector),
    .vector_valid(link_if.vector_valid), .return_done(link_if.return_done));
  // ==========
  // Clock and watchdog; the ceiling is far above the few hundred cycles used
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end
  // ==========
  // Helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  task ev(input logic [31:0] s, input logic [7:0] p, input logic [15:0] q);
    @(posedge ref_clk);
    src_req_in <= s;
    spi_event_in <= p;
    ser_event_in <= q;
    @(posedge ref_clk);
    src_req_in <= 32'h0000_0000;
    spi_event_in <= 8'h00;
    ser_event_in <= 16'h0000;
  endtask : ev
  task set_mask(input logic [2:0] m);
    @(posedge ref_clk);
    mask_in <= m;
    mask_load <= 1'b1;
    @(posedge ref_clk);
    mask_load <= 1'b0;
  endtask : set_mask
  // Bounded wait for one taken vector, then compare flag and vector together
  task take(input logic [7:0] v);
    for (int i = 0; i < 50 && taken_valid !== 1'b1; i++)
      @(posedge ref_clk) #1;
    chk({23'h0, taken_valid, taken_vector}, {24'h1, v});
  endtask : take
  task none(input int n);
    int seen;
    seen = 0;
    repeat (n)
    begin
      @(posedge ref_clk) #1;
      seen += (taken_valid === 1'b1) ? 1 : 0;
    end
    chk(seen, 0);
  endtask : none
  task finish_svc(input logic [31:0] isr);
    wr_reg(ADDR_IN_SERVICE, isr);
    @(posedge ref_clk);
    service_done <= 1'b1;
    @(posedge ref_clk);
    service_done <= 1'b0;
    // Idle lasts one cycle only when a source pends again at once
    #1 chk({31'h0, busy}, 32'h0);
  endtask : finish_svc
  // ==========
  // Scenarios
  task t_reset;
    rd_chk(ADDR_MASK, 32'h0);
    rd_chk(ADDR_PENDING, 32'h0);
    rd_chk(ADDR_IN_SERVICE, 32'h0);
    rd_chk(ADDR_SPI_EVMASK, 32'h0);
    rd_chk(ADDR_SER_EVMASK, 32'h0);
    rd_chk(ADDR_LEVEL, {29'h0, LEVEL_RESET});
    rd_chk(ADDR_VEC_BASE, {24'h0, VEC_BASE_RESET});
    rd_chk(4'hf, 32'h0);
    $display("done reset");
  endtask : t_reset
  task t_poll;
    ev(32'h8, 8'h00, 16'h0);
    none(10);
    rd_chk(ADDR_PENDING, 32'h8);
    wr_reg(ADDR_MASK, 32'h8);
    take(8'h43);
    rd_chk(ADDR_IN_SERVICE, 32'h8);
    rd_chk(ADDR_PENDING, 32'h0);
    finish_svc(32'h8);
    rd_chk(ADDR_IN_SERVICE, 32'h0);
    $display("done poll");
  endtask : t_poll
  task t_rank;
    wr_reg(ADDR_MASK, 32'h84);
    ev(32'h84, 8'h00, 16'h0);
    take(8'h47);
    finish_svc(32'h0);
    none(10);
    rd_chk(ADDR_PENDING, 32'h4);
    wr_reg(ADDR_IN_SERVICE, 32'h80);
    take(8'h42);
    finish_svc(32'h4);
    $display("done rank");
  endtask : t_rank
  task t_level;
    wr_reg(ADDR_MASK, 32'h2);
    set_mask(3'h4);
    ev(32'h2, 8'h00, 16'h0);
    none(20);
    rd_chk(ADDR_PENDING, 32'h2);
    set_mask(3'h3);
    take(8'h41);
    chk({29'h0, core_mask}, {29'h0, LEVEL_RESET});
    finish_svc(32'h2);
    chk({29'h0, core_mask}, 32'h3);
    set_mask(3'h0);
    $display("done level");
  endtask : t_level
  task t_spi;
    wr_reg(ADDR_SPI_EVMASK, {24'h0, SPI_EVENT_IMPL});
    wr_reg(ADDR_MASK, SPI_SOURCE_SEL);
    ev(32'h0, 8'hff, 16'h0);
    take(8'h45);
    rd_chk(ADDR_SPI_EVENT, 32'h37);
    wr_reg(ADDR_SPI_EVENT, 32'h0);
    rd_chk(ADDR_SPI_EVENT, 32'h37);
    wr_reg(ADDR_SPI_EVENT, 32'h1);
    rd_chk(ADDR_SPI_EVENT, 32'h36);
    finish_svc(32'h20);
    take(8'h45);
    wr_reg(ADDR_SPI_EVENT, {24'h0, SPI_CLEAR_ALL});
    rd_chk(ADDR_SPI_EVENT, 32'h0);
    finish_svc(32'h20);
    none(20);
    $display("done spi");
  endtask : t_spi
  task t_ser;
    ev(32'h0, 8'h00, 16'h3);
    rd_chk(ADDR_SER_EVENT, 32'h3);
    rd_chk(ADDR_PENDING, 32'h0);
    wr_reg(ADDR_SER_EVMASK, 32'h1);
    rd_chk(ADDR_PENDING, 32'h4000_0000);
    $display("done serial");
  endtask : t_ser
  // ==========
  // Verdict
  task results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_poll();
    t_rank();
    t_level();
    t_spi();
    t_ser();
    results();
  end
endmodule : comm_module_interrupt_controller_tb
